// *** verilog/twp_defines.svh ***
// Constants for the transponder write validation and programming block
// How it works
// - Stop command is exactly two bits; extra bits keep modulation running.
// - With protection on, 32 bits after the prefix compare with block 7, first bit first.
// - Password mismatch skips programming; read resumes at block 1 after writing.
// - With protection off, a stream carrying 32 extra password bits still programs.
// - 32 field clocks pass before programming; voltage checked meanwhile, lock checked before.
// - Programming voltage watched throughout; too low aborts at once into read mode.
// - Programming operation is held active for 16 ms.
// - After good programming, read mode starts with the block just programmed.
// - Block or sequence terminator enabled puts a block terminator before that block.
// - Reprogrammed block 0 is sent with old mode, then the new mode applies.
// - A gap interval that is neither a zero nor a one flags an error.
// - Prefix other than 10 or 11 flags an error.
// - Bit count must be 38 (protection off), 70, 34 wake-up (protection on) or 2 stop, else error.
// - Any write error skips programming; read starts at block 1 on leaving write.
// - Set lock bit or low voltage stops programming; read resumes at addressed block.
// - Zero is nominally 24 field clocks between gaps, one is 56.
// - No gap for 64 field clocks ends write mode; program only on correct count.
`ifndef TWP_DEFINES_SVH
`define TWP_DEFINES_SVH
`define TWP_REG_CTRL 3'h0
`define TWP_REG_KEY 3'h1
`define TWP_REG_LOCK 3'h2
`define TWP_REG_MODE 3'h3
`define TWP_REG_STATUS 3'h4
`define TWP_REG_DATA 3'h5
`define TWP_CTRL_PROT 0
`define TWP_CTRL_BTERM 1
`define TWP_CTRL_STERM 2
`define TWP_OP_WRITE 2'h2
`define TWP_OP_STOP 2'h3
`define TWP_ZERO_MIN 7'h10
`define TWP_ZERO_MAX 7'h20
`define TWP_ONE_MIN 7'h30
`define TWP_ONE_MAX 7'h3f
`define TWP_TIMEOUT 7'h40
`define TWP_START_DLY 20'h00020
`define TWP_CNT_STOP 7'h02
`define TWP_CNT_WAKE 7'h22
`define TWP_CNT_PLAIN 7'h26
`define TWP_CNT_KEYED 7'h46
`define TWP_KEY_BLOCK 3'h7
`define TWP_ERR_BLOCK 3'h1
`define TWP_MODE_BLOCK 3'h0
`define TWP_CORE_HZ 50000000
`define TWP_PROG_MS 16
`endif

// *** verilog/twp_pkg.sv ***
// Types shared by the transponder write validation block
`default_nettype none
package twp_pkg;
  typedef enum logic [4:0] {
    TWP_IDLE = 5'h01,
    TWP_WRITE = 5'h02,
    TWP_DELAY = 5'h04,
    TWP_PROG = 5'h08,
    TWP_SILENT = 5'h10
  } twp_state_t;
  typedef struct packed {
    logic en;
    logic lock;
    logic [2:0] blk;
    logic [31:0] data;
  } twp_prog_t;
  typedef struct packed {
    logic start;
    logic [2:0] blk;
    logic lead_term;
  } twp_read_t;
endpackage
`default_nettype wire

// *** verilog/twp_write_ctrl.sv ***
// Write decoding, validation and programming sequencer
//
// The strobed register port and the register offsets were decided locally.
`include "twp_defines.svh"
`default_nettype none
module twp_write_ctrl import twp_pkg::*; #(
  parameter logic [19:0] PROG_CYCLES = 20'(`TWP_PROG_MS * (`TWP_CORE_HZ / 1000))
) (
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic FIELD_CLK_I,
  input wire logic GAP_I,
  input wire logic VPP_OK_I,
  input wire logic BLOCK_SENT_I,
  input wire logic [2:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [31:0] RDATA_O,
  output twp_prog_t PROG_O,
  output twp_read_t READ_O,
  output logic SILENCE_O,
  output logic WRITE_MODE_O,
  output logic [31:0] ACTIVE_MODE_O
);

  logic fc1_q, fc2_q, fc3_q;
  logic gp1_q, gp2_q, gp3_q;
  logic vp1_q, vp2_q;
  twp_state_t st_q, st_d;
  logic [6:0] iv_q;
  logic [6:0] cnt_q;
  logic [1:0] op_q;
  logic [35:0] sh_q;
  logic mis_q, gerr_q;
  logic [19:0] tmr_q;
  logic [2:0] ctrl_q;
  logic [31:0] key_q;
  logic [7:0] lock_q;
  logic [31:0] mode_q, mode_new_q;
  logic pend_q;
  logic [31:0] last_q;

  function automatic logic key_bit(input logic [31:0] key, input logic [6:0] cnt);
    logic [6:0] idx;
    idx = 7'd33 - cnt;
    return key[idx[4:0]];
  endfunction

  function automatic logic in_win(input logic [6:0] v, input logic [6:0] lo,
                                  input logic [6:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction

  // Pins from the RF front end are asynchronous to the core clock
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      {fc1_q, fc2_q, fc3_q} <= 3'h0;
      {gp1_q, gp2_q, gp3_q} <= 3'h0;
      {vp1_q, vp2_q} <= 2'h0;
    end else begin
      {fc1_q, fc2_q, fc3_q} <= {FIELD_CLK_I, fc1_q, fc2_q};
      {gp1_q, gp2_q, gp3_q} <= {GAP_I, gp1_q, gp2_q};
      {vp1_q, vp2_q} <= {VPP_OK_I, vp1_q};
    end
  end

  wire fc_rise = fc2_q & ~fc3_q;
  wire gap_rise = gp2_q & ~gp3_q;
  wire vpp_ok = vp2_q;

  wire in_idle = st_q == TWP_IDLE;
  wire in_wr = st_q == TWP_WRITE;
  wire in_dly = st_q == TWP_DELAY;
  wire in_prg = st_q == TWP_PROG;

  wire is_zero = in_win(iv_q, `TWP_ZERO_MIN, `TWP_ZERO_MAX);
  wire is_one = in_win(iv_q, `TWP_ONE_MIN, `TWP_ONE_MAX);
  wire bit_ok = is_zero | is_one;
  wire bit_take = in_wr & gap_rise & bit_ok;
  wire start_gap = in_idle & gap_rise;
  wire end_wr = in_wr & (iv_q == `TWP_TIMEOUT);

  // Key bits sit right after the two prefix bits
  wire prot_en = ctrl_q[`TWP_CTRL_PROT];
  wire key_slot = (cnt_q >= 7'd2) && (cnt_q < 7'd34);
  wire key_bad = prot_en & key_slot & (is_one != key_bit(key_q, cnt_q));

  wire op_stop = op_q == `TWP_OP_STOP;
  wire op_write = op_q == `TWP_OP_WRITE;
  wire op_err = ~(op_stop | op_write);
  wire n_plain = cnt_q == `TWP_CNT_PLAIN;
  wire n_keyed = cnt_q == `TWP_CNT_KEYED;
  wire n_wake = cnt_q == `TWP_CNT_WAKE;
  wire n_stop = cnt_q == `TWP_CNT_STOP;
  // Plain mode also takes the 70-bit form so a reader may always send a password
  wire n_write = prot_en ? n_keyed : (n_plain | n_keyed);
  wire cnt_ok = op_stop ? n_stop : (n_write | (prot_en & n_wake));
  wire werr = gerr_q | op_err | mis_q | ~cnt_ok;
  wire is_stop = op_stop & n_stop;
  wire is_write = op_write & n_write;

  wire lock_in = sh_q[35];
  wire [31:0] data_in = sh_q[34:3];
  wire [2:0] addr_in = sh_q[2:0];
  wire lock_hit = lock_q[addr_in];

  wire dly_done = in_dly & (tmr_q == `TWP_START_DLY);
  wire prg_done = in_prg & (tmr_q == PROG_CYCLES - 20'h1);
  wire prg_ok = prg_done & vpp_ok;

  always_comb begin
    st_d = st_q;
    case (st_q)
      TWP_IDLE: begin
        if (gap_rise) begin
          st_d = TWP_WRITE;
        end
      end
      TWP_WRITE: begin
        if (end_wr) begin
          if (werr) begin
            st_d = TWP_IDLE;
          end else if (is_stop) begin
            st_d = TWP_SILENT;
          end else if (is_write & ~lock_hit & vpp_ok) begin
            st_d = TWP_DELAY;
          end else begin
            st_d = TWP_IDLE;
          end
        end
      end
      TWP_DELAY: begin
        if (!vpp_ok) begin
          st_d = TWP_IDLE;
        end else if (dly_done) begin
          st_d = TWP_PROG;
        end
      end
      TWP_PROG: begin
        if (!vpp_ok || prg_done) begin
          st_d = TWP_IDLE;
        end
      end
      TWP_SILENT: begin
        st_d = TWP_SILENT;
      end
      default: begin
        st_d = TWP_IDLE;
      end
    endcase
  end

  // Every return to read mode announces the block that reading starts at
  wire back_idle = ~in_idle & (st_d == TWP_IDLE);
  wire to_blk1 = in_wr & (werr | ~is_write);
  wire [2:0] rd_blk = to_blk1 ? `TWP_ERR_BLOCK : addr_in;
  wire lead_term = prg_ok & (ctrl_q[`TWP_CTRL_BTERM] | ctrl_q[`TWP_CTRL_STERM]);

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      st_q <= TWP_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  wire [6:0] iv_inc = (iv_q == 7'h7f) ? iv_q : iv_q + 7'h1;

  // The field clock stops during a gap, so the interval counter only moves between gaps
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      iv_q <= 7'h0;
    end else if (gap_rise) begin
      iv_q <= 7'h0;
    end else if (fc_rise) begin
      iv_q <= iv_inc;
    end
  end

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      cnt_q <= 7'h0;
      op_q <= 2'h0;
      sh_q <= 36'h0;
    end else if (start_gap) begin
      cnt_q <= 7'h0;
      op_q <= 2'h0;
    end else if (bit_take) begin
      cnt_q <= (cnt_q == 7'h7f) ? cnt_q : cnt_q + 7'h1;
      if (cnt_q < 7'd2) begin
        op_q <= {op_q[0], is_one};
      end else begin
        sh_q <= {sh_q[34:0], is_one};
      end
    end
  end

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      mis_q <= 1'b0;
      gerr_q <= 1'b0;
    end else if (start_gap) begin
      mis_q <= 1'b0;
      gerr_q <= 1'b0;
    end else if (in_wr & gap_rise) begin
      mis_q <= mis_q | (bit_ok & key_bad);
      gerr_q <= gerr_q | ~bit_ok;
    end
  end

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      tmr_q <= 20'h0;
    end else if (st_d != st_q) begin
      tmr_q <= 20'h0;
    end else if (in_prg | (in_dly & fc_rise)) begin
      tmr_q <= tmr_q + 20'h1;
    end
  end

  wire wr_ctrl = WR_I & (ADDR_I == `TWP_REG_CTRL);
  wire wr_key = WR_I & (ADDR_I == `TWP_REG_KEY);
  wire wr_lock = WR_I & (ADDR_I == `TWP_REG_LOCK);
  wire wr_mode = WR_I & (ADDR_I == `TWP_REG_MODE);
  wire prg_key = prg_ok & (addr_in == `TWP_KEY_BLOCK);
  wire prg_mode = prg_ok & (addr_in == `TWP_MODE_BLOCK);

  // Software loads the stored blocks at power-up; programming updates them after
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ctrl_q <= 3'h0;
      key_q <= 32'h0;
      lock_q <= 8'h0;
      last_q <= 32'h0;
    end else begin
      if (wr_ctrl) ctrl_q <= WDATA_I[2:0];
      if (prg_key) key_q <= data_in;
      else if (wr_key) key_q <= WDATA_I;
      if (prg_ok) lock_q[addr_in] <= lock_q[addr_in] | lock_in;
      else if (wr_lock) lock_q <= WDATA_I[7:0];
      if (prg_ok) last_q <= data_in;
    end
  end

  // New mode waits until the reprogrammed block went out in the old one
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      mode_q <= 32'h0;
      mode_new_q <= 32'h0;
      pend_q <= 1'b0;
    end else if (prg_mode) begin
      mode_new_q <= data_in;
      pend_q <= 1'b1;
    end else if (pend_q & BLOCK_SENT_I) begin
      mode_q <= mode_new_q;
      pend_q <= 1'b0;
    end else if (wr_mode) begin
      mode_q <= WDATA_I;
    end
  end

  wire [31:0] status = {15'h0, pend_q, cnt_q, gerr_q, mis_q, op_q, st_q};
  wire [31:0] rd_mux = (ADDR_I == `TWP_REG_CTRL) ? {29'h0, ctrl_q} :
                       (ADDR_I == `TWP_REG_KEY) ? key_q :
                       (ADDR_I == `TWP_REG_LOCK) ? {24'h0, lock_q} :
                       (ADDR_I == `TWP_REG_MODE) ? mode_q :
                       (ADDR_I == `TWP_REG_STATUS) ? status :
                       (ADDR_I == `TWP_REG_DATA) ? last_q : 32'h0;

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      RDATA_O <= 32'h0;
      PROG_O <= '0;
      READ_O <= '0;
      SILENCE_O <= 1'b0;
      WRITE_MODE_O <= 1'b0;
      ACTIVE_MODE_O <= 32'h0;
    end else begin
      RDATA_O <= RD_I ? rd_mux : 32'h0;
      PROG_O <= '{en: st_d == TWP_PROG, lock: lock_in, blk: addr_in, data: data_in};
      READ_O <= '{start: back_idle, blk: rd_blk, lead_term: lead_term};
      SILENCE_O <= st_d == TWP_SILENT;
      WRITE_MODE_O <= st_d == TWP_WRITE;
      ACTIVE_MODE_O <= mode_q;
    end
  end

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);

  a_stop_extra_bits: assert property (
    end_wr && op_stop && !n_stop |=> !SILENCE_O && READ_O.start)
    else $error("stop with extra bits silenced the device");
  a_key_mismatch: assert property (
    end_wr && mis_q |=> READ_O.start && READ_O.blk == 3'h1 && st_q == TWP_IDLE)
    else $error("password mismatch did not return to block 1");
  a_start_delay: assert property (
    in_dly && st_d == TWP_PROG |-> tmr_q == 20'h20 && vpp_ok)
    else $error("programming began before 32 field clocks");
  a_vpp_abort: assert property (
    (in_dly || in_prg) && !vpp_ok |=> st_q == TWP_IDLE && READ_O.start && !PROG_O.en)
    else $error("low voltage did not abort at once");
  a_prog_time: assert property (
    in_prg && st_d == TWP_IDLE && vpp_ok |-> tmr_q == PROG_CYCLES - 20'h1)
    else $error("programming time wrong");
  a_readback_blk: assert property (
    prg_ok |=> READ_O.start && READ_O.blk == $past(addr_in)
      && READ_O.lead_term == $past(ctrl_q[1] | ctrl_q[2]))
    else $error("read-back does not start at programmed block");
  a_gap_fail: assert property (
    in_wr && gap_rise && !bit_ok |=> gerr_q [*2])
    else $error("bad gap interval not flagged");
  a_count_check: assert property (
    end_wr && !cnt_ok |=> READ_O.start && READ_O.blk == 3'h1 && !PROG_O.en)
    else $error("wrong bit count accepted");
  a_lock_abort: assert property (
    end_wr && !werr && is_write && lock_hit |=> READ_O.blk == $past(addr_in) && in_idle)
    else $error("locked block not refused");
  a_start_clear: assert property (
    start_gap |=> cnt_q == 7'h0 && !mis_q && op_q == 2'h0 && in_wr)
    else $error("start gap did not clear write state");
  a_timeout_exit: assert property (
    end_wr |=> !in_wr)
    else $error("write mode held past 64 field clocks");
  a_prefix_check: assert property (
    end_wr && op_err |=> READ_O.start && READ_O.blk == 3'h1 && !PROG_O.en)
    else $error("bad prefix was not refused");
  a_key_compare: assert property (
    bit_take && key_bad |=> mis_q)
    else $error("password bit mismatch not latched");
  // Only a reset brings the block out of the silent state
  a_silent_hold: assert property (
    SILENCE_O |=> SILENCE_O && !PROG_O.en && !READ_O.start)
    else $error("silent state was left without reset");

  c_prog_done: cover property (prg_ok);
  c_stop_cmd: cover property (end_wr && is_stop);
  c_mode_switch: cover property (pend_q && BLOCK_SENT_I);
  c_key_reject: cover property (end_wr && mis_q);
  c_lock_refuse: cover property (end_wr && !werr && is_write && lock_hit);

endmodule
`default_nettype wire

// *** bench/twp_reader.sv ***
// Reader model that gaps the RF field to send write frames
`default_nettype none
module twp_reader (
  output logic FIELD_CLK_O,
  output logic GAP_O
);
  timeunit 1ns;
  timeprecision 1ps;
  logic run = 1'b1;
  initial FIELD_CLK_O = 1'b0;
  initial GAP_O = 1'b0;
  // The field runs freely and only stops while a gap is in it
  always #80 FIELD_CLK_O = run ? ~FIELD_CLK_O : FIELD_CLK_O;
  task automatic gap();
    run = 1'b0;
    GAP_O = 1'b1;
    #160;
    GAP_O = 1'b0;
    run = 1'b1;
  endtask
  // Bits go MSB first; bad adds one extra interval, fitting neither window, before that bit
  task automatic send(input logic [69:0] b, input int n, input int bad);
    gap();
    for (int i = n - 1; i >= 0; i--) begin
      if (i == bad) begin
        repeat (40) @(posedge FIELD_CLK_O);
        gap();
      end
      repeat (b[i] ? 56 : 24) @(posedge FIELD_CLK_O);
      gap();
    end
  endtask
endmodule
`default_nettype wire

// *** bench/transponder_write_validate_program_bench.sv ***
// Self-checking bench for the write validation and programming block
`default_nettype none
module transponder_write_validate_program_bench import twp_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PROG = 50;
  localparam logic [31:0] KEY = 32'h0000_0003;
  localparam logic [31:0] DAT = 32'h0000_0081;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic vpp_ok = 1'b1;
  logic block_sent = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [31:0] wdata = 32'h0;
  wire logic field_clk;
  wire logic gap;
  logic [31:0] rdata;
  logic [31:0] active_mode;
  twp_prog_t prog;
  twp_read_t rdo;
  logic silence;
  logic write_mode;
  int error_cnt = 0;
  int checked = 0;

  always #10 core_clk = ~core_clk;

  twp_write_ctrl #(.PROG_CYCLES(20'd50)) twp_write_ctrl_inst (
    .CORE_CLK_I(core_clk), .RST_I(rst), .FIELD_CLK_I(field_clk), .GAP_I(gap),
    .VPP_OK_I(vpp_ok), .BLOCK_SENT_I(block_sent), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .PROG_O(prog), .READ_O(rdo),
    .SILENCE_O(silence), .WRITE_MODE_O(write_mode), .ACTIVE_MODE_O(active_mode)
  );
  twp_reader twp_reader_inst (.FIELD_CLK_O(field_clk), .GAP_O(gap));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    if (error_cnt == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask

  task automatic rd_check(input logic [2:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 check(rdata, exp);
  endtask

  function automatic logic [69:0] plain(input logic [31:0] d, input logic [2:0] a);
    return {32'h0, 2'b10, 1'b0, d, a};
  endfunction

  function automatic logic [69:0] keyed(input logic [31:0] k, input logic [31:0] d,
                                        input logic [2:0] a);
    return {2'b10, k, 1'b0, d, a};
  endfunction

  // ecnt: programming cycles expected, or -1 for an aborted run
  task automatic outcome(input int ecnt, input logic [2:0] eb, input logic et,
                         input logic [31:0] ed);
    int en_cyc;
    int dly;
    logic done;
    logic [31:0] pd;
    logic [3:0] pl;
    en_cyc = 0;
    dly = 0;
    done = 1'b0;
    pd = 32'h0;
    pl = 4'h0;
    for (int n = 0; n < 4000 && !done; n++) begin
      @(posedge core_clk);
      #1;
      if (prog.en === 1'b1) begin
        en_cyc++;
        pd = prog.data;
        pl = {prog.lock, prog.blk};
      end else if (en_cyc == 0 && write_mode === 1'b0) dly++;
      done = (rdo.start === 1'b1);
    end
    check(32'(done), 32'h1);
    check(32'(rdo.blk), 32'(eb));
    if (ecnt < 0) check(32'(en_cyc > 0 && en_cyc < PROG), 32'h1);
    else check(en_cyc, ecnt);
    if (ecnt != 0) check(pd, ed);
    if (ecnt != 0) check(32'(pl), 32'({1'b0, eb}));
    if (ecnt > 0) check(32'(rdo.lead_term), 32'(et));
    if (ecnt > 0) check(32'(dly >= 246 && dly <= 268), 32'h1);
  endtask

  initial begin
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    #1 check(32'({prog.en, rdo.start, silence, write_mode}), 32'h0);
    rd_check(3'h4, 32'h1);
    wr_reg(3'h0, 32'h0);
    wr_reg(3'h2, 32'h0);
    wr_reg(3'h1, KEY);
    wr_reg(3'h3, 32'h22);
    rd_check(3'h1, KEY);
    rd_check(3'h6, 32'h0);
    check(active_mode, 32'h22);
    twp_reader_inst.send(plain(DAT, 3'h3), 38, -1);
    outcome(PROG, 3'h3, 1'b0, DAT);
    rd_check(3'h5, DAT);
    wr_reg(3'h0, 32'h2);
    twp_reader_inst.send(keyed(32'h5, DAT, 3'h2), 70, -1);
    outcome(PROG, 3'h2, 1'b1, DAT);
    wr_reg(3'h0, 32'h3);
    twp_reader_inst.send(keyed(KEY ^ 32'h1, DAT, 3'h4), 70, -1);
    outcome(0, 3'h1, 1'b1, DAT);
    wr_reg(3'h0, 32'h5);
    twp_reader_inst.send(keyed(KEY, DAT, 3'h4), 70, -1);
    outcome(PROG, 3'h4, 1'b1, DAT);
    twp_reader_inst.send({36'h0, 2'b10, KEY}, 34, -1);
    outcome(0, 3'h1, 1'b0, DAT);
    wr_reg(3'h0, 32'h0);
    for (int p = 0; p < 2; p++) begin
      twp_reader_inst.send(70'(p), 2, -1);
      outcome(0, 3'h1, 1'b0, DAT);
    end
    twp_reader_inst.send(70'h6, 3, -1);
    outcome(0, 3'h1, 1'b0, DAT);
    check(32'(silence), 32'h0);
    twp_reader_inst.send(plain(DAT, 3'h3), 38, 20);
    outcome(0, 3'h1, 1'b0, DAT);
    wr_reg(3'h2, 32'h20);
    twp_reader_inst.send(plain(DAT, 3'h5), 38, -1);
    outcome(0, 3'h5, 1'b0, DAT);
    fork
      begin
        wait (prog.en === 1'b1);
        repeat (10) @(posedge core_clk);
        vpp_ok <= 1'b0;
      end
    join_none
    twp_reader_inst.send(plain(DAT, 3'h6), 38, -1);
    outcome(-1, 3'h6, 1'b0, DAT);
    @(posedge core_clk);
    vpp_ok <= 1'b1;
    twp_reader_inst.send(plain(32'h11, 3'h0), 38, -1);
    outcome(PROG, 3'h0, 1'b0, 32'h11);
    check(active_mode, 32'h22);
    @(posedge core_clk);
    block_sent <= 1'b1;
    @(posedge core_clk);
    block_sent <= 1'b0;
    repeat (2) @(posedge core_clk);
    check(active_mode, 32'h11);
    twp_reader_inst.send(70'h3, 2, -1);
    for (int n = 0; n < 1000 && silence !== 1'b1; n++) @(posedge core_clk);
    check(32'(silence), 32'h1);
    rst <= 1'b1;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    #1 check(32'(silence), 32'h0);
    summarize();
  end

  // Frames take about 2.2 ms in all; leave some margin
  initial begin
    #2_600_000;
    error_cnt++;
    summarize();
  end
endmodule
`default_nettype wire
